// *** hw/gpio_fg_consts.vh ***
// Purpose: constants for the port F / port G general-purpose I/O block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes: register offsets are locally chosen
`ifndef GPIO_FG_CONSTS_VH
`define GPIO_FG_CONSTS_VH

`define ADDR_W 6
`define OFS_F_DATA 6'h00
`define OFS_F_DIR 6'h04
`define OFS_G_DATA 6'h08
`define OFS_G_DIR 6'h0C
`define OFS_G_PULL 6'h10
`define OFS_CTRL 6'h14
`define OFS_F_RMW 6'h18
`define OFS_G_RMW 6'h1C
`define CTRL_SPL_BIT 0
`define CTRL_RSTEN_BIT 1
`define CTRL_STBY_BIT 2
`define F_MASK 8'h07
`define G_MASK 8'h06
`define DIR_RESET 8'h00
`define DATA_RESET 8'h00
`define PULL_RESET 8'h00
`define CTRL_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hw/pin_sync3.v ***
// Purpose: three-stage synchroniser for asynchronous pin levels
// Assumes: single clock aclk, synchronous active-low reset
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
  parameter W = 8
) (
  input wire aclk, // clock
  input wire aresetn, // synchronous reset, active low
  input wire [W-1:0] din, // asynchronous pin levels
  output reg [W-1:0] dout // filtered synchronous levels
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          dout[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** hw/gpio_fg.v ***
// Purpose: port F (3 pins) and port G (2 pins) general-purpose I/O with AXI4-Lite registers
// Assumes: one clock, synchronous active-low reset, pad logic outside resolves pins
// Notes: pin outputs, enables and pull-ups come straight from flip-flops
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_fg_consts.vh"
module gpio_fg #(
  parameter [7:0] OPEN_DRAIN_F = 8'h00, // port F pins built open-drain
  parameter [7:0] OPEN_DRAIN_G = 8'h00 // port G pins built open-drain
) (
  input wire aclk, // clock, 20 MHz
  input wire aresetn, // synchronous reset, active low
  input wire [5:0] s_axi_awaddr, // write address
  input wire [2:0] s_axi_awprot, // write protection, unused
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [5:0] s_axi_araddr, // read address
  input wire [2:0] s_axi_arprot, // read protection, unused
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire read_modify_write_read, // read qualifier, sampled with arvalid
  input wire stop_or_watch_mode, // device is in stop or watch mode
  input wire [2:0] port_f_pin_i, // port F pad levels
  output reg [2:0] port_f_pin_o, // port F drive level
  output reg [2:0] port_f_pin_oe, // port F drive enable, high drives
  input wire [1:0] port_g_pin_i, // port G pad levels, pins 1 and 2
  output reg [1:0] port_g_pin_o, // port G drive level
  output reg [1:0] port_g_pin_oe, // port G drive enable, high drives
  output reg [1:0] port_g_pullup_en, // port G pull-up connect
  output reg [2:0] port_f_in_path, // port F input to peripherals
  output reg [1:0] port_g_in_path, // port G input to peripherals
  output reg standby_pin_state_bit, // standby pin-state control
  output reg external_reset_select // port F bit 2 given to reset
);
  reg [7:0] port_f_data_latch_q;
  reg [7:0] port_f_direction_q;
  reg [7:0] port_g_data_latch_q;
  reg [7:0] port_g_direction_q;
  reg [7:0] port_g_pullup_control_q;
  reg [7:0] ctrl_q;
  reg [5:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire [2:0] f_sync;
  wire [1:0] g_sync;
  wire hiz_force;
  wire do_write;
  reg [7:0] f_pins;
  reg [7:0] g_pins;
  reg [7:0] f_norm;
  reg [7:0] g_norm;
  reg [31:0] rd_d;
  reg rd_err_d;
  reg [2:0] f_oe_d;
  reg [2:0] f_o_d;
  reg [1:0] g_oe_d;
  reg [1:0] g_o_d;
  reg [1:0] g_pu_d;
  integer k;

  pin_sync3 #(.W(5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({port_g_pin_i, port_f_pin_i}),
    .dout({g_sync, f_sync})
  );

  // forced high impedance only with standby bit set
  assign hiz_force = ctrl_q[`CTRL_SPL_BIT] & stop_or_watch_mode;
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        case (awaddr_q)
          `OFS_F_DATA, `OFS_F_DIR, `OFS_G_DATA, `OFS_G_DIR, `OFS_G_PULL,
          `OFS_CTRL: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register file; only byte lane 0 holds bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_f_direction_q <= `DIR_RESET;
      port_g_direction_q <= `DIR_RESET;
      port_f_data_latch_q <= `DATA_RESET;
      port_g_data_latch_q <= `DATA_RESET;
      port_g_pullup_control_q <= `PULL_RESET;
      ctrl_q <= `CTRL_RESET;
    end else if (do_write && wstrb_q[0]) begin
      case (awaddr_q)
        `OFS_F_DATA: port_f_data_latch_q <= wdata_q[7:0] & `F_MASK;
        // only bits 0 to 2 exist on port F
        `OFS_F_DIR: port_f_direction_q <= wdata_q[7:0] & `F_MASK;
        // only bits 1 and 2 exist on port G
        `OFS_G_DATA: port_g_data_latch_q <= wdata_q[7:0] & `G_MASK;
        `OFS_G_DIR: port_g_direction_q <= wdata_q[7:0] & `G_MASK;
        `OFS_G_PULL: port_g_pullup_control_q <= wdata_q[7:0] & `G_MASK;
        `OFS_CTRL: ctrl_q <= wdata_q[7:0] & 8'h03;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // read data selection
  always @* begin
    f_pins = {5'h00, f_sync};
    g_pins = {5'h00, g_sync, 1'b0};
    for (k = 0; k < 8; k = k + 1) begin
      // input pin reads pin level, peripheral use ignored
      f_norm[k] = port_f_direction_q[k] ? port_f_data_latch_q[k] : f_pins[k];
      g_norm[k] = port_g_direction_q[k] ? port_g_data_latch_q[k] : g_pins[k];
    end
    if (hiz_force) begin
      f_norm = f_norm & port_f_direction_q;
      g_norm = g_norm & port_g_direction_q;
    end
    f_norm = f_norm & `F_MASK;
    g_norm = g_norm & `G_MASK;
    rd_err_d = 1'b0;
    rd_d = 32'h00000000;
    case (s_axi_araddr)
      // qualifier chooses latch or pin data
      `OFS_F_DATA: rd_d[7:0] = read_modify_write_read ? port_f_data_latch_q : f_norm;
      `OFS_G_DATA: rd_d[7:0] = read_modify_write_read ? port_g_data_latch_q : g_norm;
      `OFS_F_RMW: rd_d[7:0] = port_f_data_latch_q;
      `OFS_G_RMW: rd_d[7:0] = port_g_data_latch_q;
      `OFS_F_DIR: rd_d[7:0] = port_f_direction_q;
      `OFS_G_DIR: rd_d[7:0] = port_g_direction_q;
      `OFS_G_PULL: rd_d[7:0] = port_g_pullup_control_q;
      `OFS_CTRL: rd_d[7:0] = {5'h00, stop_or_watch_mode, ctrl_q[1:0]};
      default: rd_err_d = 1'b1;
    endcase
  end

  // read channel: one-cycle answer after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_err_d ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pin drive decisions
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      f_o_d[k] = port_f_data_latch_q[k];
      f_oe_d[k] = port_f_direction_q[k] & ~(OPEN_DRAIN_F[k] & port_f_data_latch_q[k]);
    end
    // reset function owns port F bit 2
    if (ctrl_q[`CTRL_RSTEN_BIT]) begin
      f_oe_d[2] = 1'b0;
    end
    for (k = 0; k < 2; k = k + 1) begin
      g_o_d[k] = port_g_data_latch_q[k+1];
      g_oe_d[k] = port_g_direction_q[k+1] & ~(OPEN_DRAIN_G[k+1] & port_g_data_latch_q[k+1]);
    end
    // force high impedance; keeps state otherwise
    if (hiz_force) begin
      f_oe_d = 3'h0;
      g_oe_d = 2'h0;
    end
    for (k = 0; k < 2; k = k + 1) begin
      g_pu_d[k] = port_g_pullup_control_q[k+1] & ~(g_oe_d[k] & ~g_o_d[k]);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      port_f_pin_o <= 3'h0;
      port_f_pin_oe <= 3'h0;
      port_g_pin_o <= 2'h0;
      port_g_pin_oe <= 2'h0;
      port_g_pullup_en <= 2'h0;
      port_f_in_path <= 3'h0;
      port_g_in_path <= 2'h0;
      standby_pin_state_bit <= 1'b0;
      external_reset_select <= 1'b0;
    end else begin
      port_f_pin_o <= f_o_d;
      port_f_pin_oe <= f_oe_d;
      port_g_pin_o <= g_o_d;
      port_g_pin_oe <= g_oe_d;
      port_g_pullup_en <= g_pu_d;
      // input path held low while isolated
      port_f_in_path <= hiz_force ? 3'h0 : f_sync;
      port_g_in_path <= hiz_force ? 2'h0 : g_sync;
      standby_pin_state_bit <= ctrl_q[`CTRL_SPL_BIT];
      external_reset_select <= ctrl_q[`CTRL_RSTEN_BIT];
    end
  end
endmodule
`default_nettype wire

// *** dv/gpio_fg_sva.sv ***
// Purpose: pin and bus timing checks for gpio_fg
// Assumes: bound to the gpio_fg ports
// Notes: pin outputs are registered, so forcing is judged after two cycles
`timescale 1ns/10ps
`default_nettype none
module gpio_fg_sva (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic stop_or_watch_mode, // standby mode
  input wire logic [2:0] port_f_pin_oe, // f enable
  input wire logic [1:0] port_g_pin_o, // g level
  input wire logic [1:0] port_g_pin_oe, // g enable
  input wire logic [1:0] port_g_pullup_en, // g pull-up
  input wire logic [2:0] port_f_in_path, // f input path
  input wire logic [1:0] port_g_in_path, // g input path
  input wire logic standby_pin_state_bit, // ctrl bit 0
  input wire logic external_reset_select // ctrl bit 1
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_f_dir_reset: assert property ($past(!aresetn) |-> port_f_pin_oe == 3'h0)
    else $error("port f driven after reset");
  chk_g_dir_reset: assert property ($past(!aresetn) |-> port_g_pin_oe == 2'h0)
    else $error("port g driven after reset");
  chk_hiz_forced: assert property ((standby_pin_state_bit && stop_or_watch_mode)[*2]
    |-> port_f_pin_oe == 3'h0 && port_g_pin_oe == 2'h0) else $error("pins not released");
  chk_input_blocked: assert property ((standby_pin_state_bit && stop_or_watch_mode)[*2]
    |-> port_f_in_path == 3'h0 && port_g_in_path == 2'h0) else $error("input not held low");
  chk_pullup_low: assert property ((port_g_pullup_en & port_g_pin_oe & ~port_g_pin_o) == 2'h0)
    else $error("pull-up on a low pin");
  chk_reset_pin: assert property (external_reset_select[*2] |-> !port_f_pin_oe[2])
    else $error("reset pin driven");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind gpio_fg gpio_fg_sva gpio_fg_sva_inst (.*);
`default_nettype wire

// *** dv/pin_pads.sv ***
// Purpose: pad model for the five port pins with external drivers
// Assumes: bit order f0 f1 f2 g1 g2
// Notes: a floating pin toggles so no stale level reads back
`timescale 1ns/10ps
`default_nettype none
module pin_pads (
  input wire logic aclk, // clock
  input wire logic [4:0] oe, // device drives
  input wire logic [4:0] o, // device level
  input wire logic [4:0] pu, // pull-up on
  input wire logic [4:0] en, // external drives
  input wire logic [4:0] v, // external level
  output logic [4:0] lvl // pad level
);
  logic [4:0] last_q = 5'h00;
  always_ff @(posedge aclk) begin
    last_q <= lvl;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      lvl[i] = oe[i] ? o[i] : en[i] ? v[i] : pu[i] ? 1'b1 : ~last_q[i];
    end
  end
endmodule
`default_nettype wire

// *** dv/test_gpio_fg.sv ***
// Purpose: self-checking bench for gpio_fg
// Assumes: byte lane 0 holds each register
// Notes: pin inputs need several cycles through the synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "gpio_fg_consts.vh"
module test_gpio_fg;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, read_modify_write_read, stop_or_watch_mode;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [4:0] ext_en, ext_v;
  wire [4:0] lvl;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire standby_pin_state_bit, external_reset_select;
  wire [1:0] s_axi_bresp, s_axi_rresp, port_g_pin_i, port_g_pin_o, port_g_pin_oe;
  wire [1:0] port_g_pullup_en, port_g_in_path;
  wire [2:0] port_f_pin_i, port_f_pin_o, port_f_pin_oe, port_f_in_path;
  wire [31:0] s_axi_rdata;
  int bad_count, cmp_count;
  assign port_f_pin_i = lvl[2:0];
  assign port_g_pin_i = lvl[4:3];
  gpio_fg gpio_fg_inst (.*);
  pin_pads pin_pads_inst (.aclk(aclk), .oe({port_g_pin_oe, port_f_pin_oe}),
    .o({port_g_pin_o, port_f_pin_o}), .pu({port_g_pullup_en, 3'h0}), .en(ext_en), .v(ext_v),
    .lvl(lvl));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task hang;
    bad_count++;
    end_sim();
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 40) hang();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({6'h0, s_axi_bresp}, {6'h0, er});
  endtask
  task rd(input logic [5:0] a, input logic q, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    read_modify_write_read <= q;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 40) hang();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check({6'h0, s_axi_rresp}, {6'h0, er});
    check(s_axi_rdata[7:0], ed);
  endtask
  task s_reset;
    aresetn <= 1'b0;
    wt(8);
    aresetn <= 1'b1;
    rd(`OFS_F_DIR, 1'b0, 8'h00, `RESP_OKAY);
    rd(`OFS_G_DIR, 1'b0, 8'h00, `RESP_OKAY);
    check({3'h0, port_g_pin_oe, port_f_pin_oe}, 8'h00);
  endtask
  task s_out;
    wr(`OFS_F_DIR, 8'hFF, `RESP_OKAY);
    wr(`OFS_F_DATA, 8'h05, `RESP_OKAY);
    wt(2);
    check({5'h0, port_f_pin_oe}, 8'h07);
    check({5'h0, port_f_pin_o}, 8'h05);
    rd(`OFS_F_DATA, 1'b0, 8'h05, `RESP_OKAY);
    rd(`OFS_F_DIR, 1'b0, 8'h07, `RESP_OKAY);
    wr(`OFS_F_DATA, 8'h02, `RESP_OKAY);
    wt(2);
    check({5'h0, port_f_pin_o}, 8'h02);
  endtask
  task s_in;
    wr(`OFS_F_DIR, 8'h00, `RESP_OKAY);
    wt(2);
    // outside drive only once the port lets go
    ext_v <= 5'h02;
    ext_en <= 5'h07;
    wr(`OFS_F_DATA, 8'h05, `RESP_OKAY);
    wt(2);
    check({5'h0, port_f_pin_oe}, 8'h00);
    wt(8);
    rd(`OFS_F_DATA, 1'b0, 8'h02, `RESP_OKAY);
    rd(`OFS_F_DATA, 1'b1, 8'h05, `RESP_OKAY);
    rd(`OFS_F_RMW, 1'b0, 8'h05, `RESP_OKAY);
    check({5'h0, port_f_in_path}, 8'h02);
    ext_en <= 5'h00;
  endtask
  task s_pull;
    wr(`OFS_G_DIR, 8'hFF, `RESP_OKAY);
    wr(`OFS_G_DATA, 8'h02, `RESP_OKAY);
    wr(`OFS_G_PULL, 8'hFF, `RESP_OKAY);
    wt(2);
    check({6'h0, port_g_pullup_en}, 8'h01);
    check({6'h0, port_g_pin_o}, 8'h01);
    check({6'h0, port_g_pin_oe}, 8'h03);
    rd(`OFS_G_PULL, 1'b0, 8'h06, `RESP_OKAY);
    wr(`OFS_G_DIR, 8'h00, `RESP_OKAY);
    wt(8);
    check({6'h0, port_g_pullup_en}, 8'h03);
    rd(`OFS_G_DATA, 1'b0, 8'h06, `RESP_OKAY);
    wr(`OFS_G_PULL, 8'h00, `RESP_OKAY);
    wt(2);
    check({6'h0, port_g_pullup_en}, 8'h00);
  endtask
  task s_standby;
    wr(`OFS_F_DIR, 8'h07, `RESP_OKAY);
    wr(`OFS_CTRL, 8'h01, `RESP_OKAY);
    stop_or_watch_mode <= 1'b1;
    wt(3);
    check({5'h0, port_f_pin_oe}, 8'h00);
    check({3'h0, port_g_in_path, port_f_in_path}, 8'h00);
    check({7'h0, standby_pin_state_bit}, 8'h01);
    rd(`OFS_CTRL, 1'b0, 8'h05, `RESP_OKAY);
    wr(`OFS_CTRL, 8'h00, `RESP_OKAY);
    wt(3);
    check({5'h0, port_f_pin_oe}, 8'h07);
    check({5'h0, port_f_pin_o}, 8'h05);
    stop_or_watch_mode <= 1'b0;
  endtask
  task s_misc;
    wr(`OFS_CTRL, 8'h02, `RESP_OKAY);
    wt(3);
    check({5'h0, port_f_pin_oe}, 8'h03);
    check({7'h0, external_reset_select}, 8'h01);
    wr(`OFS_CTRL, 8'h00, `RESP_OKAY);
    wr(6'h3C, 8'h01, `RESP_SLVERR);
    wr(`OFS_F_RMW, 8'h00, `RESP_SLVERR);
    rd(`OFS_F_RMW, 1'b0, 8'h05, `RESP_OKAY);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {read_modify_write_read, stop_or_watch_mode} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {ext_en, ext_v} = 10'h000;
    s_reset();
    s_out();
    s_in();
    s_pull();
    s_standby();
    s_misc();
    s_reset();
    end_sim();
  end
endmodule
`default_nettype wire
